// ### hdl/csd_sync.sv
/*
  Two-flop level synchroniser, width parameterised.
  Assumes inputs are static levels relative to clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module csd_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage read only by the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### hdl/csd_top.sv
/*
  Configuration switch decoder with APB register slave.
  Latches power-up switch settings, samples hold, tuning and enable
  switches periodically, drives enable, hold and offset trim.
  Assumes an APB master on clk_sys and a signed 14-bit analog sample.
*/
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "csd_defs.svh"
module csd_top
  import csd_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `CSD_SAMPLE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [`CSD_SW_COUNT-1:0] config_switch_bank,
  input wire logic hw_enable_in,
  input wire logic [13:0] command_analog_input,
  input wire logic adc_valid,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic drive_enable,
  output logic motion_hold,
  output logic tune_start,
  output logic [3:0] node_number,
  output logic serial_multidrop,
  output logic keypad_sel,
  output logic restore_all,
  output logic restore_keep_node,
  output logic autorun_block,
  output logic [15:0] input_offset_trim
);
  logic [`CSD_SW_COUNT-1:0] sw_s;
  csd_boot_t boot_q;
  logic boot_done_q;
  csd_live_t live_q;
  csd_live_t live_prev_q;
  logic hw_en_q;
  logic hw_en_prev_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [31:0] ctrl_q;
  logic [3:0] soft_node_q;
  logic combined_en_q;
  logic enable_q;
  logic tune_start_q;
  logic restore_keep_q;
  csd_trim_t trim_state_q;
  logic [4:0] trim_cnt_q;
  logic [17:0] trim_acc_q;
  logic [15:0] trim_q;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic trim_cmd;

  // Switches are asynchronous to clk_sys
  csd_sync #(
    .W(`CSD_SW_COUNT)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(config_switch_bank),
    .sync_out(sw_s)
  );

  logic hw_en_s;
  csd_sync #(
    .W(1)
  ) u_sync_en (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(hw_enable_in),
    .sync_out(hw_en_s)
  );

  // APB slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  always_comb begin
    case (paddr)
      `CSD_REG_CTRL, `CSD_REG_NODE, `CSD_REG_STATUS,
      `CSD_REG_TRIM, `CSD_REG_SWITCH: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      case (paddr)
        `CSD_REG_CTRL: prdata <= ctrl_q;
        `CSD_REG_NODE: prdata <= {28'h000_0000, soft_node_q};
        `CSD_REG_STATUS: prdata <= {20'h0_0000, node_number,
          1'b0, autorun_block, restore_keep_q, boot_q.restore_all,
          boot_q.serial_multidrop, (trim_state_q != CSD_TRIM_IDLE),
          live_q.hold, enable_q};
        `CSD_REG_TRIM: prdata <= {16'h0000, trim_q};
        `CSD_REG_SWITCH: prdata <= {22'h00_0000, sw_s};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Pulse bits self-clear; level bits hold
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CSD_CTRL_RESET;
    end else begin
      ctrl_q[`CSD_CTRL_TRIM_CMD] <= 1'b0;
      ctrl_q[`CSD_CTRL_RESTORE_CMD] <= 1'b0;
      ctrl_q[`CSD_CTRL_REBOOT] <= 1'b0;
      if (wr_en && paddr == `CSD_REG_CTRL) begin
        ctrl_q <= {27'h000_0000, pwdata[4:0]};
      end
    end
  end
  assign combined_en_q = ctrl_q[`CSD_CTRL_COMBINED];
  assign trim_cmd = ctrl_q[`CSD_CTRL_TRIM_CMD];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      soft_node_q <= `CSD_NODE_RESET;
    end else if (wr_en && paddr == `CSD_REG_NODE) begin
      soft_node_q <= pwdata[3:0];
    end
  end

  // Latched once after reset or host reboot; sync needs two edges
  logic [1:0] boot_wait_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_wait_q <= 2'h0;
      boot_done_q <= 1'b0;
      boot_q <= '0;
    end else if (ctrl_q[`CSD_CTRL_REBOOT]) begin
      boot_wait_q <= 2'h0;
      boot_done_q <= 1'b0;
    end else if (!boot_done_q) begin
      if (boot_wait_q != 2'h3) begin
        boot_wait_q <= boot_wait_q + 2'h1;
      end else begin
        boot_done_q <= 1'b1;
        // Switch 1 carries weight 8, so the bit order is reversed
        boot_q.node <= {sw_s[`CSD_SW_NODE_LSB], sw_s[`CSD_SW_NODE_LSB + 1],
          sw_s[`CSD_SW_NODE_LSB + 2], sw_s[`CSD_SW_NODE_MSB]};
        boot_q.serial_multidrop <= sw_s[`CSD_SW_SERIAL];
        boot_q.restore_all <=
          (sw_s[`CSD_SW_NODE_MSB:`CSD_SW_NODE_LSB] == `CSD_NODE_ALL_ON)
          && !sw_s[`CSD_SW_ENABLE];
        boot_q.no_autorun <= sw_s[`CSD_SW_HOLD] && sw_s[`CSD_SW_KEYPAD]
          && !sw_s[`CSD_SW_ENABLE];
        boot_q.keypad_sel <= sw_s[`CSD_SW_KEYPAD];
      end
    end
  end

  // Switch restore clears node too, software one keeps it
  assign node_number = (boot_q.node == `CSD_NODE_ALL_OFF
    || boot_q.node == `CSD_NODE_ALL_ON) ? soft_node_q : boot_q.node;
  assign serial_multidrop = boot_q.serial_multidrop;
  assign keypad_sel = boot_q.keypad_sel;
  assign restore_all = boot_q.restore_all & boot_done_q;
  assign autorun_block = boot_q.no_autorun & boot_done_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      restore_keep_q <= 1'b0;
    end else begin
      restore_keep_q <= ctrl_q[`CSD_CTRL_RESTORE_CMD];
    end
  end
  assign restore_keep_node = restore_keep_q;

  // Periodic sample tick
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_q == 32'(SAMPLE_CYCLES - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      live_q <= '0;
      live_prev_q <= '0;
    end else if (tick) begin
      live_prev_q <= live_q;
      live_q.hold <= sw_s[`CSD_SW_HOLD];
      live_q.tune <= sw_s[`CSD_SW_TUNE];
      live_q.enable <= sw_s[`CSD_SW_ENABLE];
    end
  end
  // Motion logic does the controlled stop; held while switch on
  assign motion_hold = live_q.hold;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hw_en_q <= 1'b0;
      hw_en_prev_q <= 1'b0;
    end else begin
      hw_en_q <= hw_en_s;
      hw_en_prev_q <= hw_en_q;
    end
  end

  // Combined mode arms the command on the second rising input
  logic both_on;
  logic in_rise;
  assign both_on = live_q.enable & hw_en_q;
  assign in_rise = hw_en_q & ~hw_en_prev_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enable_q <= 1'b0;
    end else if (combined_en_q) begin
      if (!both_on) begin
        enable_q <= 1'b0;
      end else if (in_rise || live_prev_q.enable != live_q.enable) begin
        enable_q <= 1'b1;
      end
    end else begin
      enable_q <= both_on & ctrl_q[`CSD_CTRL_ENCMD];
    end
  end
  assign drive_enable = enable_q;

  // Tuning start on sampled enable falling while tuning armed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tune_start_q <= 1'b0;
    end else begin
      tune_start_q <= (tick & live_q.enable & ~sw_s[`CSD_SW_ENABLE]
        & sw_s[`CSD_SW_TUNE] & live_q.tune) | trim_cmd;
    end
  end
  assign tune_start = tune_start_q;

  // Average zero-level samples into a correction
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trim_state_q <= CSD_TRIM_IDLE;
      trim_cnt_q <= 5'h00;
      trim_acc_q <= 18'h0_0000;
      trim_q <= 16'h0000;
    end else begin
      case (trim_state_q)
        CSD_TRIM_IDLE: begin
          if (tune_start_q) begin
            trim_cnt_q <= 5'h00;
            trim_acc_q <= 18'h0_0000;
            trim_state_q <= CSD_TRIM_RUN;
          end
        end
        CSD_TRIM_RUN: begin
          if (adc_valid) begin
            trim_acc_q <= trim_acc_q + {{4{command_analog_input[13]}},
              command_analog_input};
            trim_cnt_q <= trim_cnt_q + 5'h01;
            if (trim_cnt_q == 5'(`CSD_TRIM_SAMPLES - 1)) begin
              trim_state_q <= CSD_TRIM_STORE;
            end
          end
        end
        CSD_TRIM_STORE: begin
          trim_q <= 16'(-$signed(trim_acc_q[17:`CSD_TRIM_SHIFT]));
          trim_state_q <= CSD_TRIM_IDLE;
        end
        default: trim_state_q <= CSD_TRIM_IDLE;
      endcase
    end
  end
  assign input_offset_trim = trim_q;
endmodule
`default_nettype wire

// ### inc/csd_defs.svh
/*
  Constants for the configuration switch decoder: switch positions,
  APB offsets, field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH

// Switch bit positions (bit 0 is switch 1)
`define CSD_SW_NODE_MSB 3
`define CSD_SW_NODE_LSB 0
`define CSD_SW_SPARE 4
`define CSD_SW_HOLD 5
`define CSD_SW_TUNE 6
`define CSD_SW_ENABLE 7
`define CSD_SW_KEYPAD 8
`define CSD_SW_SERIAL 9
`define CSD_SW_COUNT 10

`define CSD_NODE_ALL_ON 4'hF
`define CSD_NODE_ALL_OFF 4'h0

// APB register offsets (byte addresses)
`define CSD_REG_CTRL 12'h000
`define CSD_REG_NODE 12'h004
`define CSD_REG_STATUS 12'h008
`define CSD_REG_TRIM 12'h00C
`define CSD_REG_SWITCH 12'h010

// CTRL fields
`define CSD_CTRL_ENCMD 0
`define CSD_CTRL_COMBINED 1
`define CSD_CTRL_TRIM_CMD 2
`define CSD_CTRL_RESTORE_CMD 3
`define CSD_CTRL_REBOOT 4
`define CSD_CTRL_RESET 32'h0000_0000
`define CSD_NODE_RESET 4'h1

// STATUS fields
`define CSD_ST_ENABLE 0
`define CSD_ST_HOLD 1
`define CSD_ST_TUNE_BUSY 2
`define CSD_ST_SERIAL 3
`define CSD_ST_RESTORE_ALL 4
`define CSD_ST_RESTORE_KEEP 5
`define CSD_ST_NO_AUTORUN 6
`define CSD_ST_NODE_LSB 8

// Timing
`define CSD_CLK_HZ 100000000
`define CSD_SAMPLE_MS 100
`define CSD_SAMPLE_CYCLES ((`CSD_CLK_HZ / 1000) * `CSD_SAMPLE_MS)
`define CSD_TRIM_SAMPLES 16
`define CSD_TRIM_SHIFT 4

`endif

// ### inc/csd_pkg.sv
/*
  Types for the configuration switch decoder.
  Assumes csd_defs.svh is on the include path.
*/
`include "csd_defs.svh"
package csd_pkg;
  typedef struct packed {
    logic [3:0] node;
    logic serial_multidrop;
    logic restore_all;
    logic no_autorun;
    logic keypad_sel;
  } csd_boot_t;

  typedef struct packed {
    logic hold;
    logic tune;
    logic enable;
  } csd_live_t;

  typedef enum logic [1:0] {
    CSD_TRIM_IDLE,
    CSD_TRIM_RUN,
    CSD_TRIM_STORE
  } csd_trim_t;
endpackage

// ### test/csd_props.sv
/*
  Port checker for csd_top, bound into every instance.
  Assumes the register map of csd_defs.svh and a short sample period.
*/
`timescale 1ns/1ns
`default_nettype none
`include "csd_defs.svh"
module csd_props #(
  parameter int SAMPLE_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [`CSD_SW_COUNT-1:0] config_switch_bank,
  input wire logic hw_enable_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic drive_enable,
  input wire logic motion_hold,
  input wire logic tune_start,
  input wire logic [3:0] node_number,
  input wire logic serial_multidrop,
  input wire logic keypad_sel,
  input wire logic restore_keep_node
);
  // Sample tick plus synchroniser slack
  localparam int FALL_MAX = SAMPLE_CYCLES + 10;
  logic [3:0] quiet_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Boot latch and relatch settle well inside 15 cycles
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      quiet_q <= 4'h0;
    end else if (psel && pwrite) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h010
    |-> pslverr) else $error("no error on unmapped address");
  a_enable_drop: assert property ($fell(hw_enable_in)
    |-> ##[1:FALL_MAX] !drive_enable) else $error("enable stuck");
  a_tune_single: assert property (tune_start |=> !tune_start)
    else $error("tune start too long");
  a_keep_cause: assert property (psel && penable && pwrite
    && paddr == 12'h000 && pwdata[3] |-> ##[1:2] restore_keep_node)
    else $error("soft restore missing");
  a_keep_single: assert property (restore_keep_node
    |=> !restore_keep_node) else $error("soft restore too long");
  a_boot_frozen: assert property (quiet_q == 4'hF
    |-> $stable(node_number) && $stable(serial_multidrop)
    && $stable(keypad_sel)) else $error("boot value moved");
  a_hold_rose: assert property ($rose(motion_hold)
    |-> config_switch_bank[`CSD_SW_HOLD]) else $error("hold without switch");
endmodule
bind csd_top csd_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_props (
  .clk_sys(clk_sys), .rst(rst), .config_switch_bank(config_switch_bank),
  .hw_enable_in(hw_enable_in), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .drive_enable(drive_enable),
  .motion_hold(motion_hold), .tune_start(tune_start),
  .node_number(node_number), .serial_multidrop(serial_multidrop),
  .keypad_sel(keypad_sel), .restore_keep_node(restore_keep_node));
`default_nettype wire

// ### test/csd_sw_model.sv
/*
  Operator model for the front-panel switch bank.
  Assumes the bench calls set; lever moves land just after an edge.
*/
`timescale 1ns/1ns
`default_nettype none
`include "csd_defs.svh"
module csd_sw_model (
  input wire logic clk_sys,
  output logic [`CSD_SW_COUNT-1:0] bank
);
  logic [`CSD_SW_COUNT-1:0] want = 10'h000;
  initial bank = 10'h000;
  always @(posedge clk_sys) begin
    bank <= want;
  end
  // All-on node only for a deliberate restore
  task automatic set(input logic [`CSD_SW_COUNT-1:0] v);
    want = v;
  endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
/*
  Self-checking bench for csd_top with APB master and switch model.
  Assumes SAMPLE_CYCLES of 20 and zero-wait APB answers.
*/
`timescale 1ns/1ns
`default_nettype none
`include "csd_defs.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hw_enable_in = 1'b0;
  logic [13:0] ain = 14'h0000;
  logic adc_valid = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, drive_enable, motion_hold, tune_start;
  logic [3:0] node_number;
  logic serial_multidrop, keypad_sel, restore_all, restore_keep_node;
  logic autorun_block;
  logic [`CSD_SW_COUNT-1:0] bank;
  logic [32:0] q[$];
  logic [2:0] bits;
  logic [3:0] nval;
  int seed = 77384;
  int mismatches = 0;
  int num_checks = 0;
  int tcnt = 0;
  int kcnt = 0;
  always #5 clk_sys = ~clk_sys;
  csd_sw_model swm (.clk_sys(clk_sys), .bank(bank));
  csd_top #(.SAMPLE_CYCLES(20)) dut (
    .clk_sys(clk_sys), .rst(rst), .config_switch_bank(bank),
    .hw_enable_in(hw_enable_in), .command_analog_input(ain),
    .adc_valid(adc_valid), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_enable(drive_enable),
    .motion_hold(motion_hold), .tune_start(tune_start),
    .node_number(node_number), .serial_multidrop(serial_multidrop),
    .keypad_sel(keypad_sel), .restore_all(restore_all),
    .restore_keep_node(restore_keep_node), .autorun_block(autorun_block),
    .input_offset_trim());
  always @(posedge clk_sys) begin
    ain <= 14'($random(seed));
    adc_valid <= ~adc_valid;
  end
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) begin
      chk({pslverr, prdata}, q.pop_front());
    end
  end
  always @(negedge clk_sys) begin
    tcnt += int'(tune_start === 1'b1);
    kcnt += int'(restore_keep_node === 1'b1);
  end
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Relatch runs through the reboot bit, like a host-tool reset
  task automatic reboot(input logic [9:0] v);
    swm.set(v);
    wt(10);
    apb(`CSD_REG_CTRL, 1'b1, 32'h10);
    wt(30);
  endtask
  function automatic logic [9:0] mk(input logic [3:0] n, input logic [5:0] hi);
    return {hi, n[0], n[1], n[2], n[3]};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    swm.set(mk(4'h5, 6'h20));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    wt(30);
    chk(33'(node_number), 33'h5);
    rd(`CSD_REG_STATUS, 33'h508);
    swm.set(mk(4'h9, 6'h01));
    wt(60);
    chk(33'({node_number, serial_multidrop}), 33'hB);
    $display("boot test done");
    for (int i = 0; i < 8; i++) begin
      bits = (i == 0) ? 3'h7 : 3'($random(seed));
      apb(`CSD_REG_CTRL, 1'b1, {31'h0, bits[2]});
      hw_enable_in <= bits[0];
      swm.set(mk(4'h5, {2'h2, bits[1], 3'h0}));
      wt(60);
      chk(33'(drive_enable), 33'(&bits));
    end
    $display("enable test done");
    swm.set(mk(4'h5, 6'h2E));
    wt(60);
    chk(33'(motion_hold), 33'h1);
    tcnt = 0;
    swm.set(mk(4'h5, 6'h24));
    wt(60);
    chk(33'({motion_hold, 4'(tcnt)}), 33'h1);
    swm.set(mk(4'h5, 6'h28));
    wt(60);
    tcnt = 0;
    swm.set(mk(4'h5, 6'h20));
    wt(60);
    chk(33'(tcnt), 33'h0);
    $display("hold and tune test done");
    rd(12'h014, 33'h1_0000_0000);
    nval = 4'(1 + {$random(seed)} % 14);
    apb(`CSD_REG_NODE, 1'b1, {28'h0, nval});
    rd(`CSD_REG_NODE, 33'(nval));
    reboot(mk(4'h0, 6'h20));
    chk(33'({restore_all, node_number}), 33'(nval));
    reboot(mk(4'hF, 6'h20));
    chk(33'(restore_all), 33'h1);
    reboot(mk(4'h5, 6'h32));
    chk(33'({autorun_block, keypad_sel, restore_all}), 33'h6);
    kcnt = 0;
    apb(`CSD_REG_CTRL, 1'b1, 32'h8);
    wt(5);
    chk(33'({4'(kcnt), node_number}), 33'h15);
    $display("register test done");
    results();
  end
endmodule
`default_nettype wire
